// ### vector_map_params.svh
`ifndef VECTOR_MAP_PARAMS_SVH
`define VECTOR_MAP_PARAMS_SVH
`define VEC_ADDR_W 12
`define VEC_NUM_W 5
`define NUM_SOURCES 25
`define RESET_WORD_ADDR 12'h000
`define TABLE_BASE_ADDR 12'h001
`define RESET_VECTOR_NUM 5'h01
`define BOOT_RESET_ADDR_DEFAULT 12'hc00
`endif

// ### vector_map_pkg.sv
package vector_map_pkg;
	typedef logic [11:0] word_addr_t;
	typedef logic [4:0]  vector_num_t;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_RESET = 3'b010,
		ST_IRQ   = 3'b100
	} state_e;
endpackage : vector_map_pkg

// ### reset_interrupt_vector_map.sv
`include "vector_map_params.svh"
// Behaviour
// - Reset vectors to word 0x000 while the fuse is unprogrammed
// - External requests zero, one at 0x001, 0x002
// - Pin-change groups 0x003-0x005, watchdog 0x006
// - Second 8-bit timer at 0x007-0x009
// - 16-bit timer events at 0x00A-0x00D
// - First 8-bit timer at 0x00E-0x010
// - SPI transfer complete at 0x011
// - Serial port events at 0x012-0x014
// - Conversion done 0x015, nonvolatile ready 0x016
// - Comparator 0x017, two-wire 0x018, store 0x019
// - Fuse and select bit place vectors
// - One word per vector slot
// - Programmed fuse starts at boot address
// - Select bit moves table to boot start
module reset_interrupt_vector_map
	import vector_map_pkg::*;
#(
	parameter word_addr_t BOOT_RESET_ADDR = `BOOT_RESET_ADDR_DEFAULT
) (
	input  wire logic                     clk,
	input  wire logic                     rst,
	input  wire logic                     boot_reset_fuse,
	input  wire logic                     vector_table_select,
	input  wire logic [`NUM_SOURCES-1:0]  irq_pending,
	input  wire logic                     irq_ack,
	output logic                          vector_valid,
	output logic                          vector_is_reset,
	output word_addr_t                    vector_addr,
	output vector_num_t                   vector_num
);

	// Source index i (bit 0 = ext_request_zero) maps to vector i+2
	function automatic vector_num_t lowest_pending(input logic [`NUM_SOURCES-1:0] req);
		vector_num_t n;
		n = 5'h00;
		for (int i = `NUM_SOURCES - 1; i >= 0; i--) begin
			if (req[i]) begin
				n = 5'(i + 2);
			end
		end
		return n;
	endfunction : lowest_pending

	// Fuse low means programmed
	function automatic word_addr_t reset_location(input logic fuse);
		return fuse ? `RESET_WORD_ADDR : BOOT_RESET_ADDR;
	endfunction : reset_location

	function automatic word_addr_t table_location(input logic sel, input vector_num_t num);
		word_addr_t base;
		base = sel ? BOOT_RESET_ADDR : `RESET_WORD_ADDR;
		return base + word_addr_t'(num - 5'h01);
	endfunction : table_location

	state_e      state;
	logic        fuse_meta;
	logic        fuse_sync;
	logic        boot_fuse_q;
	logic        sel_q;
	vector_num_t next_num;

	always_comb begin
		next_num = lowest_pending(irq_pending);
	end

	// Fuse level comes from outside the clock domain
	always_ff @(posedge clk) begin
		fuse_meta <= boot_reset_fuse;
		fuse_sync <= fuse_meta;
	end

	// Fuse sampled while in reset, held afterwards
	always_ff @(posedge clk) begin
		if (rst) begin
			boot_fuse_q <= fuse_sync;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sel_q <= 1'b0;
		end else begin
			sel_q <= vector_table_select;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= ST_RESET;
		end else begin
			case (state)
				ST_RESET: begin
					if (irq_ack) begin
						state <= ST_IDLE;
					end
				end
				ST_IRQ: begin
					if (irq_ack) begin
						state <= ST_IDLE;
					end
				end
				default: begin
					if (next_num != 5'h00) begin
						state <= ST_IRQ;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			vector_valid    <= 1'b0;
			vector_is_reset <= 1'b0;
			vector_addr     <= `RESET_WORD_ADDR;
			vector_num      <= 5'h00;
		end else begin
			case (state)
				ST_RESET: begin
					vector_valid    <= ~irq_ack;
					vector_is_reset <= ~irq_ack;
					vector_num      <= `RESET_VECTOR_NUM;
					vector_addr     <= reset_location(boot_fuse_q);
				end
				ST_IRQ: begin
					if (irq_ack) begin
						vector_valid <= 1'b0;
					end
				end
				default: begin
					vector_is_reset <= 1'b0;
					if (next_num != 5'h00) begin
						vector_valid <= 1'b1;
						vector_num   <= next_num;
						vector_addr  <= table_location(sel_q, next_num);
					end
				end
			endcase
		end
	end

	property p_reset_first;
		@(posedge clk) $fell(rst) |=> vector_valid && vector_is_reset && vector_num == 5'h01;
	endproperty
	a_reset_first: assert property (p_reset_first) else $error("reset vector not offered");

	property p_reset_addr;
		@(posedge clk) disable iff (rst) vector_is_reset |-> vector_addr == (boot_fuse_q ? 12'h000 : BOOT_RESET_ADDR);
	endproperty
	a_reset_addr: assert property (p_reset_addr) else $error("reset address wrong");

	property p_irq_addr;
		@(posedge clk) disable iff (rst)
			(vector_valid && !vector_is_reset) |->
			vector_addr == (sel_q ? BOOT_RESET_ADDR : 12'h000) + 12'(vector_num) - 12'h001;
	endproperty
	a_irq_addr: assert property (p_irq_addr) else $error("table address wrong");

	property p_ext0;
		@(posedge clk) disable iff (rst) (vector_valid && vector_num == 5'h02 && !sel_q) |-> vector_addr == 12'h001;
	endproperty
	a_ext0: assert property (p_ext0) else $error("ext zero address wrong");

	property p_store_last;
		@(posedge clk) disable iff (rst) (vector_valid && vector_num == 5'h1a && !sel_q) |-> vector_addr == 12'h019;
	endproperty
	a_store_last: assert property (p_store_last) else $error("last vector address wrong");

	sequence s_idle_req;
		state == ST_IDLE && irq_pending[0] && !rst;
	endsequence
	property p_priority;
		@(posedge clk) disable iff (rst) s_idle_req |=> vector_valid && vector_num == 5'h02;
	endproperty
	a_priority: assert property (p_priority) else $error("lowest vector not chosen");

	property p_spi;
		@(posedge clk) disable iff (rst)
			(state == ST_IDLE && irq_pending == 25'h0010000) |=> vector_num == 5'h12;
	endproperty
	a_spi: assert property (p_spi) else $error("spi vector wrong");

	property p_ack_drop;
		@(posedge clk) disable iff (rst) (state == ST_IRQ && irq_ack) |=> !vector_valid;
	endproperty
	a_ack_drop: assert property (p_ack_drop) else $error("valid held after ack");

	property p_in_reset;
		@(posedge clk) rst |=> !vector_valid;
	endproperty
	a_in_reset: assert property (p_in_reset) else $error("vector offered during reset");

	property p_reset_num;
		@(posedge clk) disable iff (rst) vector_is_reset |-> vector_num == 5'h01;
	endproperty
	a_reset_num: assert property (p_reset_num) else $error("reset vector number wrong");

	// Offer stands unchanged until the core accepts it
	property p_stands;
		@(posedge clk) disable iff (rst) (vector_valid && !irq_ack) |=> vector_valid && $stable(vector_addr);
	endproperty
	a_stands: assert property (p_stands) else $error("offer changed before ack");

	property p_ext1;
		@(posedge clk) disable iff (rst) (vector_valid && vector_num == 5'h03 && !sel_q) |-> vector_addr == 12'h002;
	endproperty
	a_ext1: assert property (p_ext1) else $error("ext one address wrong");

	property p_group_a;
		@(posedge clk) disable iff (rst) (vector_valid && vector_num == 5'h04 && !sel_q) |-> vector_addr == 12'h003;
	endproperty
	a_group_a: assert property (p_group_a) else $error("group a address wrong");

	property p_group_c;
		@(posedge clk) disable iff (rst) (vector_valid && vector_num == 5'h06 && !sel_q) |-> vector_addr == 12'h005;
	endproperty
	a_group_c: assert property (p_group_c) else $error("group c address wrong");

	property p_watchdog;
		@(posedge clk) disable iff (rst) (vector_valid && vector_num == 5'h07 && !sel_q) |-> vector_addr == 12'h006;
	endproperty
	a_watchdog: assert property (p_watchdog) else $error("watchdog address wrong");

	property p_t2_first;
		@(posedge clk) disable iff (rst) (vector_valid && vector_num == 5'h08 && !sel_q) |-> vector_addr == 12'h007;
	endproperty
	a_t2_first: assert property (p_t2_first) else $error("second timer compare address wrong");

	property p_t2_last;
		@(posedge clk) disable iff (rst) (vector_valid && vector_num == 5'h0a && !sel_q) |-> vector_addr == 12'h009;
	endproperty
	a_t2_last: assert property (p_t2_last) else $error("second timer overflow address wrong");

	property p_t16_first;
		@(posedge clk) disable iff (rst) (vector_valid && vector_num == 5'h0b && !sel_q) |-> vector_addr == 12'h00a;
	endproperty
	a_t16_first: assert property (p_t16_first) else $error("wide timer capture address wrong");

	property p_t16_last;
		@(posedge clk) disable iff (rst) (vector_valid && vector_num == 5'h0e && !sel_q) |-> vector_addr == 12'h00d;
	endproperty
	a_t16_last: assert property (p_t16_last) else $error("wide timer overflow address wrong");

	property p_t1_first;
		@(posedge clk) disable iff (rst) (vector_valid && vector_num == 5'h0f && !sel_q) |-> vector_addr == 12'h00e;
	endproperty
	a_t1_first: assert property (p_t1_first) else $error("first timer compare address wrong");

	property p_t1_last;
		@(posedge clk) disable iff (rst) (vector_valid && vector_num == 5'h11 && !sel_q) |-> vector_addr == 12'h010;
	endproperty
	a_t1_last: assert property (p_t1_last) else $error("first timer overflow address wrong");

	property p_serial_rx;
		@(posedge clk) disable iff (rst) (vector_valid && vector_num == 5'h13 && !sel_q) |-> vector_addr == 12'h012;
	endproperty
	a_serial_rx: assert property (p_serial_rx) else $error("receive address wrong");

	property p_serial_tx;
		@(posedge clk) disable iff (rst) (vector_valid && vector_num == 5'h15 && !sel_q) |-> vector_addr == 12'h014;
	endproperty
	a_serial_tx: assert property (p_serial_tx) else $error("transmit address wrong");

	property p_convert;
		@(posedge clk) disable iff (rst) (vector_valid && vector_num == 5'h16 && !sel_q) |-> vector_addr == 12'h015;
	endproperty
	a_convert: assert property (p_convert) else $error("conversion address wrong");

	property p_nv_ready;
		@(posedge clk) disable iff (rst) (vector_valid && vector_num == 5'h17 && !sel_q) |-> vector_addr == 12'h016;
	endproperty
	a_nv_ready: assert property (p_nv_ready) else $error("nonvolatile ready address wrong");

	property p_two_wire;
		@(posedge clk) disable iff (rst) (vector_valid && vector_num == 5'h19 && !sel_q) |-> vector_addr == 12'h018;
	endproperty
	a_two_wire: assert property (p_two_wire) else $error("two wire address wrong");

	// Table moved to the boot start
	property p_moved;
		@(posedge clk) disable iff (rst) (vector_valid && vector_num == 5'h02 && sel_q) |-> vector_addr == BOOT_RESET_ADDR + 12'h001;
	endproperty
	a_moved: assert property (p_moved) else $error("moved table address wrong");

endmodule : reset_interrupt_vector_map

// ### core_model.sv
module core_model (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic vector_valid,
	input  wire logic slow,
	output logic      irq_ack
);
	timeunit 1ns;
	timeprecision 1ns;
	logic held;
	// One ack per offer, a cycle late when slow
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_ack <= 1'b0;
			held    <= 1'b0;
		end else begin
			held    <= vector_valid && !irq_ack && !held;
			irq_ack <= vector_valid && !irq_ack && (!slow || held);
		end
	end
endmodule : core_model

// ### test_reset_interrupt_vector_map.sv
module test_reset_interrupt_vector_map import vector_map_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam word_addr_t BOOT = 12'h400;
	logic        clk = 0, rst = 1, fuse = 1, sel = 0, slow = 0, ack, valid, is_rst;
	logic [24:0] pend = '0;
	word_addr_t  addr;
	vector_num_t num;
	int          failures = 0, checks = 0, cyc = 0;

	reset_interrupt_vector_map #(.BOOT_RESET_ADDR(BOOT)) DUT (.clk(clk), .rst(rst), .boot_reset_fuse(fuse),
		.vector_table_select(sel), .irq_pending(pend), .irq_ack(ack), .vector_valid(valid),
		.vector_is_reset(is_rst), .vector_addr(addr), .vector_num(num));
	core_model partner (.clk(clk), .rst(rst), .vector_valid(valid), .slow(slow), .irq_ack(ack));

	initial forever #10 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			failures++;
			summarize();
		end
	end

	task automatic chk(string what, logic [11:0] exp, logic [11:0] got);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Wait for an offer, check it, clear the source, wait for withdrawal
	task automatic expect_vec(logic r, vector_num_t n, word_addr_t a);
		int k;
		@(negedge clk);
		for (k = 0; k < 20 && valid !== 1'b1; k++) @(negedge clk);
		chk("valid", 12'h001, {11'h000, valid});
		chk("is_reset", {11'h000, r}, {11'h000, is_rst});
		chk("num", {7'h00, n}, {7'h00, num});
		chk("addr", a, addr);
		@(posedge clk);
		pend <= '0;
		for (k = 0; k < 20 && valid !== 1'b0; k++) @(negedge clk);
	endtask : expect_vec

	task automatic do_reset(logic f);
		@(posedge clk);
		rst  <= 1'b1;
		fuse <= f;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
	endtask : do_reset

	task automatic summarize;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : summarize

	initial begin
		do_reset(1'b1);
		expect_vec(1'b1, 5'h01, 12'h000);
		$display("reset vector test done");
		for (int i = 0; i < 25; i++) begin
			@(posedge clk);
			slow <= i[0];
			pend <= 25'h1 << i;
			expect_vec(1'b0, 5'(i + 2), 12'(i + 1));
		end
		$display("vector table test done");
		@(posedge clk);
		sel <= 1'b1;
		@(posedge clk);
		pend <= 25'h1000001;
		expect_vec(1'b0, 5'h02, BOOT + 12'h001);
		@(posedge clk);
		pend <= 25'h1000000;
		expect_vec(1'b0, 5'h1a, BOOT + 12'h019);
		$display("moved table test done");
		do_reset(1'b0);
		expect_vec(1'b1, 5'h01, BOOT);
		$display("boot reset test done");
		summarize();
	end
endmodule : test_reset_interrupt_vector_map
